//--- ssi_incremental_encoder_interface.sv
// Encoder front end: SSI master/listener, quadrature counter, diagnostics
// Behaviour
// RQ1: Position length 12 to 28 bits
// RQ2: Binary or Gray position decoding
// RQ3: Master generates 150 kHz clock, captures data
// RQ4: Master drives clock, encoder returns data
// RQ5: Listener only samples external clock and data
// RQ6: External clock at most 200/350 kHz
// RQ7: External clock pause 30 us to 1 ms
// RQ8: Clock fault outside 100 to 350 kHz
// RQ9: Fault if position change exceeds 2*V*T
// RQ10: Listener beat error accepted, not compensated
// RQ11: Frame length with position, fault, warning bits
// RQ12: Quadrature decode of tracks A and B
// RQ13: Fault if track counts differ over 4
// RQ14: Sine/cosine pulses counted like quadrature
// RQ15: Proximity switches deliver normal and complement tracks
// RQ16: Higher resolution sensor is process sensor
// RQ17: Diagnostic faults latch until reset or clear
`timescale 1ns/1ps
`include "enc_defines.svh"
module ssi_incremental_encoder_interface #(
  parameter int EVAL_CYC   = `EVAL_CNT,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                clk_in,         // System clock, 10 MHz
  input  wire logic                rst_in,         // Async reset, active high
  input  wire logic                clr_in,         // Reconfiguration: clear faults
  input  wire enc_pkg::ssi_cfg_t   cfg_in,         // SSI frame layout and mode
  input  wire enc_pkg::inc_type_t  inc_type_in,    // Incremental sensor flavour
  input  wire logic [4:0]          ssi_res_in,     // SSI resolution, log2
  input  wire logic [4:0]          inc_res_in,     // Incremental resolution, log2
  input  wire logic [15:0]         speed_in,       // Speed, increments per ms
  input  wire logic                ssi_clk_in,     // External SSI clock (listener)
  input  wire logic                ssi_data_in,    // SSI data from encoder
  output logic                     ssi_clk_out,    // SSI clock to encoder
  output logic                     ssi_clk_oe_out, // Clock driver enable
  input  wire logic                trk_a_in,       // Track A
  input  wire logic                trk_b_in,       // Track B
  input  wire logic                trk_an_in,      // Track A complement
  input  wire logic                trk_bn_in,      // Track B complement
  output logic [27:0]              ssi_pos_out,    // Decoded SSI position
  output logic [2:0]               ssi_fault_out,  // Encoder fault status bits
  output logic [2:0]               ssi_warn_out,   // Encoder warning/ready bits
  output logic [31:0]              inc_pos_out,    // Incremental position
  output logic [31:0]              proc_pos_out,   // Process sensor position
  output logic [31:0]              ref_pos_out,    // Reference sensor position
  output logic                     proc_ssi_out,   // Process sensor is SSI
  output logic                     new_pos_out,    // New SSI word published
  output enc_pkg::enc_fault_t      faults_out      // Latched diagnostics
);
  typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH, M_GAP} mst_st_t;
  localparam int HALF_C = `SSI_HALF_CNT;
  localparam int TW     = $clog2(EVAL_CYC);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] field(input logic [31:0] w,
                                        input logic [5:0]  top,
                                        input logic [5:0]  len);
    return (w >> (top - len)) & ((32'h1 << len) - 32'h1);
  endfunction : field

  function automatic logic [27:0] gray2bin(input logic [27:0] g);
    logic [27:0] b;
    b = '0;
    for (int i = 0; i < 28; i++) begin
      b[i] = ^(g >> i);
    end
    return b;
  endfunction : gray2bin

  function automatic logic [31:0] abs32(input logic [31:0] v);
    return v[31] ? 32'h0 - v : v;
  endfunction : abs32

  // ---------------------------------------------------------------
  // Pin synchronisers and evaluation tick
  // ---------------------------------------------------------------
  logic [5:0]          pins_s;
  logic                s_clk, s_dat, s_a, s_b, s_an, s_bn;
  logic [TW-1:0]       tick_cnt_ff;
  logic                tick_ff;
  enc_pkg::ssi_cfg_t   cfg;

  assign cfg = cfg_in;
  enc_sync2 #(.W(6)) u_pins (.clk_in(clk_in), .rst_in(rst_in),
    .d_in({ssi_clk_in, ssi_data_in, trk_a_in, trk_b_in, trk_an_in, trk_bn_in}),
    .q_out(pins_s));
  assign {s_clk, s_dat, s_a, s_b, s_an, s_bn} = pins_s;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else begin
      tick_ff     <= tick_cnt_ff == TW'(EVAL_CYC - 1);
      tick_cnt_ff <= (tick_cnt_ff == TW'(EVAL_CYC - 1)) ? '0 : tick_cnt_ff + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Configuration check
  // ---------------------------------------------------------------
  logic cfg_bad;
  // RQ1: length window
  assign cfg_bad = (cfg.data_len < 5'(`DATA_LEN_MIN)) ||
                   (cfg.data_len > 5'(`DATA_LEN_MAX)) ||
                   (cfg.frame_len > 6'(`FRAME_MAX)) ||
                   ({1'b0, cfg.data_len} + 6'(cfg.fault_bits) + 6'(cfg.warn_bits)
                    > cfg.frame_len);

  // ---------------------------------------------------------------
  // SSI master
  // ---------------------------------------------------------------
  mst_st_t     st_ff;
  logic [8:0]  half_ff;
  logic [5:0]  mbit_ff;
  logic [31:0] msr_ff;
  logic        mdone_ff;

  // RQ3: clock from divider
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff    <= M_IDLE;
      half_ff  <= '0;
      mbit_ff  <= '0;
      msr_ff   <= '0;
      mdone_ff <= 1'b0;
    end else begin
      mdone_ff <= 1'b0;
      unique case (st_ff)
        M_IDLE: begin
          half_ff <= '0;
          mbit_ff <= '0;
          if (tick_ff && !cfg.listen && !cfg_bad) begin
            st_ff <= M_LOW;
          end
        end
        M_LOW: begin
          half_ff <= (half_ff == 9'(HALF_C - 1)) ? '0 : half_ff + 1'b1;
          if (half_ff == 9'(HALF_C - 1)) begin
            st_ff <= M_HIGH;
          end
        end
        M_HIGH: begin
          half_ff <= (half_ff == 9'(HALF_C - 1)) ? '0 : half_ff + 1'b1;
          if (half_ff == 9'(HALF_C - 1)) begin
            // RQ11: frame length in clocks
            msr_ff  <= {msr_ff[30:0], s_dat};
            mbit_ff <= mbit_ff + 1'b1;
            if (mbit_ff == cfg.frame_len - 6'h1) begin
              st_ff    <= M_GAP;
              mdone_ff <= 1'b1;
            end else begin
              st_ff <= M_LOW;
            end
          end
        end
        M_GAP: begin
          half_ff <= half_ff + 1'b1;
          if (half_ff == 9'(`GAP_CNT - 1)) begin
            st_ff <= M_IDLE;
          end
        end
      endcase
    end
  end

  // Clock idles high; the driver is off entirely while listening
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ssi_clk_out    <= 1'b1;
      ssi_clk_oe_out <= 1'b0;
    end else begin
      ssi_clk_out    <= st_ff != M_LOW;
      // RQ4: drive in master only
      ssi_clk_oe_out <= !cfg.listen;
    end
  end

  // ---------------------------------------------------------------
  // Clock frequency monitor and frame gap detect
  // ---------------------------------------------------------------
  logic       mon, mon_d_ff, gap_ff, freq_bad_ff;
  logic [8:0] per_ff, idle_ff;
  logic       mon_rise, mon_edge;

  assign mon      = cfg.listen ? s_clk : ssi_clk_out;
  assign mon_rise = mon && !mon_d_ff;
  assign mon_edge = mon ^ mon_d_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mon_d_ff    <= 1'b1;
      per_ff      <= 9'(`GAP_CNT);
      idle_ff     <= 9'(`GAP_CNT);
      gap_ff      <= 1'b1;
      freq_bad_ff <= 1'b0;
    end else begin
      mon_d_ff <= mon;
      per_ff   <= mon_rise ? 9'h1 : (per_ff == 9'(`GAP_CNT) ? per_ff : per_ff + 1'b1);
      idle_ff  <= mon_edge ? 9'h0 : (idle_ff == 9'(`GAP_CNT) ? idle_ff : idle_ff + 1'b1);
      gap_ff   <= !mon_edge && (idle_ff >= 9'(`GAP_CNT - 1));
      // RQ8: period outside open band
      freq_bad_ff <= mon_rise && (per_ff < 9'(`GAP_CNT)) &&
                     ((per_ff >= 9'(`PER_MAX_CNT)) || (per_ff <= 9'(`PER_MIN_CNT)));
    end
  end

  // ---------------------------------------------------------------
  // SSI listener on the external clock
  // ---------------------------------------------------------------
  // The frame gap resets the bit counter asynchronously: the external
  // clock stands still between bursts, so no edge can clear it.
  logic        lk_rst;
  logic [5:0]  lk_cnt_ff, lk_len;
  logic [31:0] lk_sr_ff;
  logic        lk_last, wr_ready, rd_valid, rd_ready;
  logic [31:0] rd_data;

  assign lk_rst = rst_in || gap_ff;

  enc_sync2 #(.W(6)) u_len (.clk_in(ssi_clk_in), .rst_in(rst_in),
                            .d_in(cfg.frame_len), .q_out(lk_len));

  // RQ5: listener drives nothing
  always_ff @(posedge ssi_clk_in or posedge lk_rst) begin
    if (lk_rst) begin
      lk_cnt_ff <= '0;
      lk_sr_ff  <= '0;
    end else begin
      lk_sr_ff  <= {lk_sr_ff[30:0], ssi_data_in};
      lk_cnt_ff <= (lk_cnt_ff == 6'h3f) ? lk_cnt_ff : lk_cnt_ff + 1'b1;
    end
  end

  // Word is pushed on the last edge itself; a full FIFO drops the frame
  assign lk_last = lk_cnt_ff == lk_len - 6'h1;

  enc_cdc_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wr_clk_in    (ssi_clk_in),
    .wr_rst_in    (rst_in),
    .wr_valid_in  (lk_last && wr_ready),
    .wr_data_in   ({lk_sr_ff[30:0], ssi_data_in}),
    .wr_ready_out (wr_ready),
    .rd_clk_in    (clk_in),
    .rd_rst_in    (rst_in),
    .rd_valid_out (rd_valid),
    .rd_data_out  (rd_data),
    .rd_ready_in  (rd_ready)
  );

  // ---------------------------------------------------------------
  // Word latch and decode at the evaluation tick
  // ---------------------------------------------------------------
  logic [31:0] raw_ff;
  logic        raw_vld_ff, dec_go;
  logic [27:0] ssi_pos_ff;
  logic [27:0] dat_fld;
  logic [2:0]  flt_fld;

  // One word waits per tick, so the FIFO fills when frames run faster
  assign rd_ready = cfg.listen && !raw_vld_ff;
  assign dec_go   = tick_ff && raw_vld_ff;
  assign dat_fld  = 28'(field(raw_ff, cfg.frame_len, {1'b0, cfg.data_len}));
  assign flt_fld  = 3'(field(raw_ff, cfg.frame_len - {1'b0, cfg.data_len},
                             6'(cfg.fault_bits)));

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      raw_ff     <= '0;
      raw_vld_ff <= 1'b0;
    end else if (mdone_ff) begin
      raw_ff     <= msr_ff;
      raw_vld_ff <= 1'b1;
    end else if (rd_ready && rd_valid) begin
      raw_ff     <= rd_data;
      raw_vld_ff <= 1'b1;
    end else if (dec_go) begin
      raw_vld_ff <= 1'b0;
    end
  end

  // RQ10: oldest queued word, no beat compensation
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ssi_pos_ff    <= '0;
      ssi_fault_out <= '0;
      ssi_warn_out  <= '0;
      new_pos_out   <= 1'b0;
    end else begin
      new_pos_out <= dec_go;
      if (dec_go) begin
        // RQ2: Gray or binary
        ssi_pos_ff    <= cfg.gray ? gray2bin(dat_fld) : dat_fld;
        // RQ11: status fields follow position
        ssi_fault_out <= flt_fld;
        ssi_warn_out  <= 3'(field(raw_ff, cfg.frame_len - {1'b0, cfg.data_len} -
                                  6'(cfg.fault_bits), 6'(cfg.warn_bits)));
      end
    end
  end
  assign ssi_pos_out = ssi_pos_ff;

  // ---------------------------------------------------------------
  // Quadrature counter, per-track counts
  // ---------------------------------------------------------------
  logic        a_d_ff, b_d_ff;
  logic [31:0] inc_pos_ff;
  logic [15:0] cnt_a_ff, cnt_b_ff;
  logic [31:0] dev_abs;

  // RQ12: 4x decode, RQ14: squared sine/cosine same path
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      a_d_ff     <= 1'b0;
      b_d_ff     <= 1'b0;
      inc_pos_ff <= '0;
      cnt_a_ff   <= '0;
      cnt_b_ff   <= '0;
    end else begin
      a_d_ff <= s_a;
      b_d_ff <= s_b;
      if ((s_a ^ a_d_ff) != (s_b ^ b_d_ff)) begin
        inc_pos_ff <= ((s_a ^ a_d_ff) ? (s_a != s_b) : (s_b == s_a)) ?
                      inc_pos_ff + 32'h1 : inc_pos_ff - 32'h1;
      end
      // RQ13: each track counted alone
      // Edges are counted without sign: a stuck track shows up even when
      // the other one only dithers back and forth
      if (s_a ^ a_d_ff) begin
        cnt_a_ff <= cnt_a_ff + 16'h1;
      end
      if (s_b ^ b_d_ff) begin
        cnt_b_ff <= cnt_b_ff + 16'h1;
      end
    end
  end
  assign dev_abs = abs32(32'(signed'(cnt_a_ff - cnt_b_ff)));
  assign inc_pos_out = inc_pos_ff;

  // ---------------------------------------------------------------
  // Sensor roles and plausibility
  // ---------------------------------------------------------------
  logic [31:0] proc_now, last_ff, delta, limit;
  logic        plaus_vld_ff;

  assign proc_now = proc_ssi_out ? {4'h0, ssi_pos_ff} : inc_pos_ff;
  assign delta    = abs32(proc_now - last_ff);
  assign limit    = 32'(speed_in) * 32'(`PLAUS_FACTOR * `EVAL_MS);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      proc_ssi_out <= 1'b1;
      proc_pos_out <= '0;
      ref_pos_out  <= '0;
    end else begin
      // RQ16: finer sensor leads
      proc_ssi_out <= ssi_res_in >= inc_res_in;
      proc_pos_out <= proc_now;
      ref_pos_out  <= proc_ssi_out ? inc_pos_ff : {4'h0, ssi_pos_ff};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_ff      <= '0;
      plaus_vld_ff <= 1'b0;
    end else if (tick_ff) begin
      last_ff      <= proc_now;
      plaus_vld_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Fault latch
  // ---------------------------------------------------------------
  enc_pkg::enc_fault_t nf, faults_ff;

  always_comb begin
    nf.cfg       = cfg_bad;
    nf.clk_freq  = freq_bad_ff;
    // RQ9: change beyond 2*V*T
    nf.plaus     = tick_ff && plaus_vld_ff && (delta > limit);
    nf.track_dev = dev_abs > 32'(`TRACK_DEV_MAX);
    // RQ15: complement must differ
    nf.prox_pair = (inc_type_in == enc_pkg::INC_PROX) && ((s_a == s_an) || (s_b == s_bn));
    nf.ssi_stat  = dec_go && (flt_fld != 3'h0);
  end

  // RQ17: sticky, new events beat clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      faults_ff <= '0;
    end else begin
      faults_ff <= clr_in ? nf : (faults_ff | nf);
    end
  end
  assign faults_out = faults_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence clk_low_s;
    $fell(ssi_clk_out);
  endsequence
  sequence clk_high_s;
    $rose(ssi_clk_out);
  endsequence

  mst_half_a: assert property (clk_low_s |-> ##HALF_C clk_high_s) // RQ3
    else $error("master clock low phase has wrong length");
  clk_oe_a: assert property (st_ff != M_IDLE ##1 !cfg.listen |-> ssi_clk_oe_out) // RQ4
    else $error("master clock not driven during frame");
  lis_quiet_a: assert property (cfg.listen [*2] |-> !ssi_clk_oe_out) // RQ5
    else $error("clock driven while listening");
  frame_len_a: assert property (mdone_ff |-> mbit_ff == cfg.frame_len) // RQ11
    else $error("master frame bit count wrong");
  gray_dec_a: assert property (dec_go && cfg.gray |=>
    (ssi_pos_ff ^ (ssi_pos_ff >> 1)) == $past(dat_fld)) // RQ2
    else $error("gray decode mismatch");
  clk_freq_a: assert property (mon_rise && per_ff < 9'(`GAP_CNT) &&
    per_ff >= 9'(`PER_MAX_CNT) |-> ##2 faults_ff.clk_freq) // RQ8
    else $error("slow clock not flagged");
  track_dev_a: assert property (dev_abs > 32'(`TRACK_DEV_MAX) |=> faults_ff.track_dev) // RQ13
    else $error("track deviation not flagged");
  cfg_len_a: assert property (cfg.data_len > 5'(`DATA_LEN_MAX) |=> faults_ff.cfg) // RQ1
    else $error("bad data length not flagged");
  plaus_a: assert property (tick_ff && plaus_vld_ff && delta > limit |=> faults_ff.plaus) // RQ9
    else $error("implausible position not flagged");
  fault_hold_a: assert property (!clr_in |=> ($past(faults_ff) & ~faults_ff) == '0) // RQ17
    else $error("latched fault lost without clear");
endmodule : ssi_incremental_encoder_interface

//--- enc_defines.svh
// Timing, layout and limit constants of the encoder front end
`ifndef ENC_DEFINES_SVH
`define ENC_DEFINES_SVH
`define ENC_CLK_HZ    10000000
`define SSI_MST_HZ    150000
`define SSI_HALF_CNT  (`ENC_CLK_HZ / (2 * `SSI_MST_HZ))
`define EVAL_MS       8
`define EVAL_CNT      (`ENC_CLK_HZ / 1000 * `EVAL_MS)
`define FCLK_MIN_HZ   100000
`define FCLK_MAX_HZ   350000
`define PER_MAX_CNT   (`ENC_CLK_HZ / `FCLK_MIN_HZ)
`define PER_MIN_CNT   (`ENC_CLK_HZ / `FCLK_MAX_HZ)
`define GAP_MIN_US    30
`define GAP_CNT       (`ENC_CLK_HZ / 1000000 * `GAP_MIN_US)
`define DATA_LEN_MIN  12
`define DATA_LEN_MAX  28
`define FRAME_MAX     32
`define TRACK_DEV_MAX 4
`define PLAUS_FACTOR  2
`endif

//--- enc_pkg.sv
// Types shared by the encoder front end
package enc_pkg;
  typedef enum logic [1:0] {INC_QUAD, INC_SINCOS, INC_PROX} inc_type_t;
  typedef struct packed {
    logic [5:0] frame_len;  // Total clock cycles per frame
    logic [4:0] data_len;   // Position bits
    logic [2:0] fault_bits; // Status fault bits after the position
    logic [2:0] warn_bits;  // Warning/ready bits after the faults
    logic       gray;       // Position is Gray coded
    logic       listen;     // Passive listener instead of master
  } ssi_cfg_t;
  typedef struct packed {
    logic cfg;
    logic clk_freq;
    logic plaus;
    logic track_dev;
    logic prox_pair;
    logic ssi_stat;
  } enc_fault_t;
endpackage : enc_pkg

//--- enc_sync2.sv
// Two-flop synchroniser for a vector of quasi-independent bits
`timescale 1ns/1ps
module enc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in, // Destination clock
  input  wire logic         rst_in, // Async reset, active high
  input  wire logic [W-1:0] d_in,   // Foreign-domain input
  output logic      [W-1:0] q_out   // Synchronised output
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      q_out   <= '0;
    end else begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end
endmodule : enc_sync2

//--- enc_cdc_fifo.sv
// Dual-clock FIFO with Gray-coded pointers
`timescale 1ns/1ps
module enc_cdc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  input  wire logic         wr_clk_in,    // Write clock
  input  wire logic         wr_rst_in,    // Write-side reset
  input  wire logic         wr_valid_in,  // Write request
  input  wire logic [W-1:0] wr_data_in,   // Write word
  output logic              wr_ready_out, // Not full
  input  wire logic         rd_clk_in,    // Read clock
  input  wire logic         rd_rst_in,    // Read-side reset
  output logic              rd_valid_out, // Not empty
  output logic      [W-1:0] rd_data_out,  // Head word
  input  wire logic         rd_ready_in   // Pop request
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wbin_ff, rbin_ff, wgray_ff, rgray_ff, rgray_w, wgray_r;
  logic          full, empty;

  function automatic logic [AW:0] b2g(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : b2g

  enc_sync2 #(.W(AW + 1)) u_r2w (.clk_in(wr_clk_in), .rst_in(wr_rst_in),
                                 .d_in(rgray_ff), .q_out(rgray_w));
  enc_sync2 #(.W(AW + 1)) u_w2r (.clk_in(rd_clk_in), .rst_in(rd_rst_in),
                                 .d_in(wgray_ff), .q_out(wgray_r));

  assign full         = wgray_ff == {~rgray_w[AW:AW-1], rgray_w[AW-2:0]};
  assign empty        = rgray_ff == wgray_r;
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem[rbin_ff[AW-1:0]];

  always_ff @(posedge wr_clk_in) begin
    if (wr_valid_in && !full) begin
      mem[wbin_ff[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge wr_clk_in or posedge wr_rst_in) begin
    if (wr_rst_in) begin
      wbin_ff  <= '0;
      wgray_ff <= '0;
    end else if (wr_valid_in && !full) begin
      wbin_ff  <= wbin_ff + 1'b1;
      wgray_ff <= b2g(wbin_ff + 1'b1);
    end
  end

  always_ff @(posedge rd_clk_in or posedge rd_rst_in) begin
    if (rd_rst_in) begin
      rbin_ff  <= '0;
      rgray_ff <= '0;
    end else if (rd_ready_in && !empty) begin
      rbin_ff  <= rbin_ff + 1'b1;
      rgray_ff <= b2g(rbin_ff + 1'b1);
    end
  end
endmodule : enc_cdc_fifo

//--- ssi_encoder_model.sv
// Behavioural SSI absolute encoder that answers the device's clock
`timescale 1ns/1ps
module ssi_encoder_model #(
  parameter int N = 14
) (
  input  wire logic         sclk_in,  // Clock from the device
  input  wire logic         oe_in,    // Device drives the clock
  input  wire logic [N-1:0] word_in,  // Frame to send, MSB first
  output logic              data_out  // Data line back to the device
);
  logic [N-1:0] shreg_ff;
  int           left_ff;
  initial begin
    data_out = 1'b1;
    left_ff  = 0;
    shreg_ff = '0;
  end
  always @(negedge sclk_in) begin
    if (oe_in && left_ff == 0) begin
      shreg_ff <= word_in;
      left_ff  <= N;
    end
  end
  always @(posedge sclk_in) begin
    if (left_ff > 0) begin
      data_out <= shreg_ff[N-1];
      shreg_ff <= shreg_ff << 1;
      left_ff  <= left_ff - 1;
    end
    // Monoflop: line returns high well after the last sample point
    if (left_ff == 1) begin
      data_out <= #15000 1'b1;
    end
  end
endmodule : ssi_encoder_model

//--- ssi_incremental_encoder_interface_test.sv
// Self-checking bench of the encoder front end in master mode
`timescale 1ns/1ps
module ssi_incremental_encoder_interface_test;
  localparam logic [11:0] GP = 12'h5a3;
  logic               clk_in = 1'b0;
  logic               rst_in = 1'b1;
  logic               clr_in = 1'b0;
  enc_pkg::ssi_cfg_t  cfg    = '{6'h0e, 5'h0c, 3'h1, 3'h1, 1'b0, 1'b0};
  enc_pkg::inc_type_t itype  = enc_pkg::INC_QUAD;
  logic               a      = 1'b0;
  logic               b      = 1'b0;
  logic               an     = 1'b1;
  logic               bn     = 1'b1;
  logic [13:0]        word   = {12'h9c4, 2'b01};
  logic [1:0]         seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  logic [4:0]         sres   = 5'h0c;
  logic [15:0]        speed  = 16'hffff;
  logic [31:0]        rpos;
  logic               sclk, soe, sdata, npos, psel;
  logic [27:0]        spos;
  logic [2:0]         sflt, swrn;
  logic [31:0]        ipos, ppos;
  enc_pkg::enc_fault_t flt;
  int                 n_fail = 0;
  int                 checked = 0;
  always #50 clk_in = ~clk_in;
  ssi_encoder_model #(.N(14)) enc (.sclk_in(sclk), .oe_in(soe), .word_in(word),
    .data_out(sdata));
  ssi_incremental_encoder_interface #(.EVAL_CYC(1500), .FIFO_DEPTH(8)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .clr_in(clr_in), .cfg_in(cfg),
    // no external master, so the listener clock stays idle high
    .inc_type_in(itype), .ssi_res_in(sres), .inc_res_in(5'h04),
    .speed_in(speed), .ssi_clk_in(1'b1), .ssi_data_in(sdata),
    .ssi_clk_out(sclk), .ssi_clk_oe_out(soe), .trk_a_in(a), .trk_b_in(b),
    .trk_an_in(an), .trk_bn_in(bn), .ssi_pos_out(spos), .ssi_fault_out(sflt),
    .ssi_warn_out(swrn), .inc_pos_out(ipos), .proc_pos_out(ppos),
    .ref_pos_out(rpos), .proc_ssi_out(psel), .new_pos_out(npos), .faults_out(flt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input logic [1:0] ab);
    @(posedge clk_in);
    a  <= ab[1];
    b  <= ab[0];
    an <= ~ab[1];
    bn <= ~ab[0];
    repeat (4) @(posedge clk_in);
  endtask : step
  // Waits for the one-cycle publish pulse, bounded by 4000 clock cycles
  task automatic wait_pos;
    int k;
    k = 0;
    @(posedge clk_in);
    while (npos !== 1'b1 && k < 4000) begin
      @(posedge clk_in);
      k++;
    end
    if (k == 4000) begin
      chk(32'h0, 32'h1);
    end
  endtask : wait_pos
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    chk(sclk, 1);
    chk(soe, 0);
    chk(flt, 0);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(soe, 1);
    wait_pos();
    chk(spos, 28'h9c4);
    chk(sflt, 3'h0);
    chk(swrn, 3'h1);
    chk(psel, 1);
    repeat (2) @(posedge clk_in);
    chk(ppos, 32'h9c4);
    // Old word is already in flight, so the gray result comes one frame later
    cfg.gray <= 1'b1;
    word     <= {GP ^ (GP >> 1), 2'b01};
    wait_pos();
    wait_pos();
    chk(spos, {16'h0, GP});
    chk(flt.clk_freq, 0);
    chk(flt.plaus, 0);
    for (int i = 0; i < 6; i++) begin
      step(seq[i % 4]);
    end
    chk(ipos, 32'h6);
    chk(flt.track_dev, 0);
    for (int i = 0; i < 5; i++) begin
      step({~a, b});
    end
    repeat (2) @(posedge clk_in);
    chk(ipos, 32'h7);
    chk(flt.track_dev, 1);
    sres <= 5'h02;
    repeat (3) @(posedge clk_in);
    chk(psel, 0);
    chk(ppos, 32'h7);
    chk(rpos, {20'h0, GP});
    itype <= enc_pkg::INC_PROX;
    @(posedge clk_in);
    an <= a;
    repeat (4) @(posedge clk_in);
    chk(flt.prox_pair, 1);
    an <= ~a;
    repeat (4) @(posedge clk_in);
    clr_in <= 1'b1;
    @(posedge clk_in);
    clr_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(flt.prox_pair, 0);
    wrap_up();
  end
endmodule : ssi_incremental_encoder_interface_test
